/* logic/tcpwm_pkg.sv */
`default_nettype none
package tcpwm_pkg;

  localparam int ADDR_W = 8;
  localparam int PSC_W  = 6;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CSR0   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_VAL0   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CSR1   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_VAL1   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_HFC    = 8'h1C;

  // Field positions in the counter control/status word and the HFC register
  localparam int CTRL_WRAP_FLAG = 7;
  localparam int CTRL_WRAP_IE   = 6;
  localparam int CTRL_HALT      = 5;
  localparam int CTRL_CLEAR     = 4;
  localparam int CTRL_PS_MSB    = 2;
  localparam int HFC_HALT_FLAG_CLEAR_ENABLE       = 7;

  // Reset values
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic        HALT_RST   = 1'b1;

  // Encodings
  localparam logic [2:0] PS_EXT   = 3'h7;
  localparam logic [1:0] ELS_NONE = 2'h0;
  localparam logic [1:0] ELS_TOG  = 2'h1;
  localparam logic [1:0] ELS_CLR  = 2'h2;
  localparam logic [1:0] ELS_SET  = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {MODE_PRESET, MODE_CAPTURE, MODE_COMPARE, MODE_BUFFERED} tcpwm_mode_t;

  // Bit order equals the channel control/status word, bit 7 down to bit 0
  typedef struct packed {
    logic       flag;
    logic       ie;
    logic       link;
    logic       func;
    logic [1:0] els;
    logic       tov;
    logic       full;
  } tcpwm_chcsr_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } tcpwm_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tcpwm_axi_rsp_t;

  typedef struct packed {
    logic [15:0]       cnt, period, val0, val1;
    logic              halt, wrap_flag, wrap_ie, halt_flag_clear_enable;
    logic [2:0]        ps;
    tcpwm_chcsr_t      csr0, csr1;
    logic              arm_wrap, arm0, arm1, act_sel, last_sel;
    logic              out0, out1, oe0, oe1, irq, ext_in, ch1_rel;
    logic [1:0]        sync1, sync2, sync3;
    logic              aw_rdy, w_rdy, aw_held, w_held, bvalid, ar_rdy, rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
  } tcpwm_st_t;

  typedef struct packed {
    logic [PSC_W-1:0] div;
    logic [2:0]       ext;
  } tcpwm_psc_t;

endpackage
`default_nettype wire

/* logic/tcpwm_presc.sv */
`timescale 1ns/10ps
`default_nettype none
module tcpwm_presc
  import tcpwm_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] sel,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic       ext_pin,
  output logic            tick
);

  tcpwm_psc_t s_reg;
  tcpwm_psc_t s_next;
  logic       ext_rise;

  function automatic logic [PSC_W-1:0] div_mask(input logic [2:0] code);
    logic [PSC_W:0] one_hot;
    one_hot  = (PSC_W+1)'(1) << code;
    div_mask = PSC_W'(one_hot - (PSC_W+1)'(1));
  endfunction

  always_comb begin
    s_next     = s_reg;
    s_next.ext = {s_reg.ext[1:0], ext_pin};
    // Edge taken from the second and third stages only
    ext_rise   = s_reg.ext[1] & ~s_reg.ext[2];
    if (clear) begin
      s_next.div = '0;
    end else if (run) begin
      s_next.div = s_reg.div + PSC_W'(1);
    end
    if (!run || clear) begin
      tick = 1'b0;
    end else if (sel == PS_EXT) begin
      tick = ext_rise;
    end else begin
      tick = (s_reg.div & div_mask(sel)) == div_mask(sel);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // tcpwm_presc
`default_nettype wire

/* logic/tcpwm_top.sv */
// Contract
// - Unbuffered value rewrite mid-period may distort output up to two periods.
// - New compare value already passed gives no compare in that period.
// - Link bit joins channels into buffered output on channel 0 pin.
// - Last written value pair governs width from next overflow.
// - Linked: channel 1 control unused, channel 1 pin returns to GPIO.
// - Mode select 0:1 unbuffered, 1:0 buffered; overflow toggle written 1.
// - Edge/level 1:0 clears on compare, 1:1 sets on compare.
// - Link bit overrides channel 0 function bit.
// - Overflow toggle clear: no overflow toggle, compares idle, 0% duty; here compares still apply their clear/set/toggle action.
// - Full duty force with overflow toggle gives 100% duty.
// - Wrap flag set at period limit; interrupt only when enabled.
// - Channel flag on capture or compare; interrupt only when enabled.
// - Wait mode: counting continues, registers refused, enabled irq wakes.
// - Counter halts during break.
// - Break: flag clears only with halt-flag-clear enable set.
// - Armed two-step clear survives break, completes after it.
// - Divider select all ones counts external clock pin edges.
// - Sixteen-bit up-counter bounded by period limit.
// - Output toggles at period limit when overflow toggle set.
// - Pulse width spans overflow to compare match.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module tcpwm_top
  import tcpwm_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire tcpwm_axi_req_t  axi_req,
  output tcpwm_axi_rsp_t       axi_rsp,
  input  wire logic            break_active,
  input  wire logic            wait_mode,
  input  wire logic            channel0_pin_in,
  input  wire logic            channel1_pin_in,
  input  wire logic            external_count_clock,
  output logic                 channel0_pin_out,
  output logic                 channel0_pin_oe,
  output logic                 channel1_pin_out,
  output logic                 channel1_pin_oe,
  output logic                 channel1_gpio_release,
  output logic                 ext_clock_pin_input,
  output logic                 irq
);

  tcpwm_st_t         s_reg;
  tcpwm_st_t         s_next;
  logic              tick;
  logic              run;
  logic              cnt_clr;
  logic              aw_fire;
  logic              w_fire;
  logic              ar_fire;
  logic              do_wr;
  logic              may_clr;
  logic              clr_wrap;
  logic              clr0;
  logic              clr1;
  logic              lnk;
  logic              ovf;
  logic              match0;
  logic              match1;
  logic              cap0;
  logic              cap1;
  logic [15:0]       nxt;
  logic [15:0]       cmp0;
  logic [ADDR_W-1:0] wa;
  logic [31:0]       wd;
  logic [3:0]        ws;
  tcpwm_mode_t       m0;
  tcpwm_mode_t       m1;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = old;
    if (st[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (st[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  function automatic tcpwm_mode_t mode_of(input tcpwm_chcsr_t c);
    if (c.els == ELS_NONE) begin
      mode_of = MODE_PRESET;
    end else if (c.link) begin
      mode_of = MODE_BUFFERED;
    end else if (c.func) begin
      mode_of = MODE_COMPARE;
    end else begin
      mode_of = MODE_CAPTURE;
    end
  endfunction

  function automatic logic cap_edge(input tcpwm_chcsr_t c, input logic now, input logic was);
    case (c.els)
      ELS_TOG: cap_edge = now & ~was;
      ELS_CLR: cap_edge = ~now & was;
      ELS_SET: cap_edge = now ^ was;
      default: cap_edge = 1'b0;
    endcase
  endfunction

  // Next pin level of a channel in its current mode
  function automatic logic pwm_out(input logic cur, input tcpwm_chcsr_t c,
                                   input tcpwm_mode_t m, input logic ov, input logic mt);
    logic r;
    r = cur;
    case (m)
      MODE_PRESET: begin
        r = ~c.func;
      end
      MODE_CAPTURE: begin
        r = cur;
      end
      default: begin
        if (c.full && c.tov) begin
          r = (c.els == ELS_SET) ? 1'b0 : 1'b1;
        end else begin
          if (ov && c.tov) begin
            r = ~r;
          end
          // Compare after toggle, so a value of zero yields 0% duty
          if (mt) begin
            case (c.els)
              ELS_TOG: r = ~r;
              ELS_CLR: r = 1'b0;
              ELS_SET: r = 1'b1;
              default: r = r;
            endcase
          end
        end
      end
    endcase
    pwm_out = r;
  endfunction

  // Break freezes the count; wait mode does not
  assign run = ~s_reg.halt & ~break_active;

  tcpwm_presc u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (s_reg.ps),
    .run     (run),
    .clear   (cnt_clr),
    .ext_pin (external_count_clock),
    .tick    (tick)
  );

  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = {channel1_pin_in, channel0_pin_in};
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;

    aw_fire  = axi_req.awvalid & s_reg.aw_rdy;
    w_fire   = axi_req.wvalid & s_reg.w_rdy;
    ar_fire  = axi_req.arvalid & s_reg.ar_rdy;
    may_clr  = ~break_active | s_reg.halt_flag_clear_enable;
    clr_wrap = 1'b0;
    clr0     = 1'b0;
    clr1     = 1'b0;
    cnt_clr  = 1'b0;

    if (aw_fire) begin
      s_next.awaddr  = axi_req.awaddr;
      s_next.aw_held = 1'b1;
    end
    if (w_fire) begin
      s_next.wdata  = axi_req.wdata;
      s_next.wstrb  = axi_req.wstrb;
      s_next.w_held = 1'b1;
    end
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    do_wr = s_next.aw_held & s_next.w_held & ~s_reg.bvalid;
    wa    = {s_next.awaddr[ADDR_W-1:2], 2'b00};
    wd    = s_next.wdata;
    ws    = s_next.wstrb;

    if (do_wr) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = RESP_OKAY;
      if (wait_mode) begin
        s_next.bresp = RESP_SLVERR;
      end else begin
        case (wa)
          OFS_CTRL: begin
            if (ws[0]) begin
              s_next.wrap_ie = wd[CTRL_WRAP_IE];
              s_next.halt    = wd[CTRL_HALT];
              cnt_clr        = wd[CTRL_CLEAR];
              s_next.ps      = wd[CTRL_PS_MSB:0];
              clr_wrap       = ~wd[CTRL_WRAP_FLAG];
            end
          end
          OFS_COUNT: begin
          end
          OFS_PERIOD: begin
            s_next.period = merge16(s_reg.period, wd, ws);
          end
          OFS_CSR0: begin
            if (ws[0]) begin
              s_next.csr0 = {s_reg.csr0.flag, wd[6:0]};
              clr0        = ~wd[7];
            end
          end
          OFS_CSR1: begin
            if (ws[0]) begin
              s_next.csr1 = {s_reg.csr1.flag, wd[6], 1'b0, wd[4:0]};
              clr1        = ~wd[7];
            end
          end
          OFS_VAL0: begin
            s_next.val0     = merge16(s_reg.val0, wd, ws);
            s_next.last_sel = 1'b0;
          end
          OFS_VAL1: begin
            s_next.val1     = merge16(s_reg.val1, wd, ws);
            s_next.last_sel = 1'b1;
          end
          OFS_HFC: begin
            if (ws[0]) begin
              s_next.halt_flag_clear_enable = wd[HFC_HALT_FLAG_CLEAR_ENABLE];
            end
          end
          default: begin
            s_next.bresp = RESP_DECERR;
          end
        endcase
      end
    end

    if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = '0;
      if (wait_mode) begin
        s_next.rresp = RESP_SLVERR;
      end else begin
        case ({axi_req.araddr[ADDR_W-1:2], 2'b00})
          OFS_CTRL: begin
            s_next.rdata[CTRL_WRAP_FLAG]  = s_reg.wrap_flag;
            s_next.rdata[CTRL_WRAP_IE]    = s_reg.wrap_ie;
            s_next.rdata[CTRL_HALT]       = s_reg.halt;
            s_next.rdata[CTRL_PS_MSB:0]   = s_reg.ps;
            // First step of the flag clear; frozen during protected break
            if (s_reg.wrap_flag && may_clr) begin
              s_next.arm_wrap = 1'b1;
            end
          end
          OFS_COUNT:  s_next.rdata[15:0] = s_reg.cnt;
          OFS_PERIOD: s_next.rdata[15:0] = s_reg.period;
          OFS_CSR0: begin
            s_next.rdata[7:0] = s_reg.csr0;
            if (s_reg.csr0.flag && may_clr) begin
              s_next.arm0 = 1'b1;
            end
          end
          OFS_CSR1: begin
            s_next.rdata[7:0] = s_reg.csr1;
            if (s_reg.csr1.flag && may_clr) begin
              s_next.arm1 = 1'b1;
            end
          end
          OFS_VAL0:   s_next.rdata[15:0] = s_reg.val0;
          OFS_VAL1:   s_next.rdata[15:0] = s_reg.val1;
          OFS_HFC:    s_next.rdata[HFC_HALT_FLAG_CLEAR_ENABLE] = s_reg.halt_flag_clear_enable;
          default:    s_next.rresp = RESP_DECERR;
        endcase
      end
    end
    s_next.aw_rdy = ~s_next.aw_held & ~s_next.bvalid;
    s_next.w_rdy  = ~s_next.w_held & ~s_next.bvalid;
    s_next.ar_rdy = ~s_next.rvalid;

    // Counter and events
    lnk  = s_reg.csr0.link;
    m0   = mode_of(s_reg.csr0);
    m1   = mode_of(s_reg.csr1);
    nxt  = (s_reg.cnt == s_reg.period) ? 16'h0000 : s_reg.cnt + 16'h0001;
    ovf  = tick & ~cnt_clr & (s_reg.cnt == s_reg.period);
    cmp0 = (lnk && s_reg.act_sel) ? s_reg.val1 : s_reg.val0;
    // Equality only: a value already passed is simply missed
    match0 = tick & ~cnt_clr & (nxt == cmp0) &
             ((m0 == MODE_COMPARE) | (m0 == MODE_BUFFERED));
    match1 = tick & ~cnt_clr & ~lnk & (nxt == s_reg.val1) & (m1 == MODE_COMPARE);
    cap0   = (m0 == MODE_CAPTURE) & cap_edge(s_reg.csr0, s_reg.sync2[0], s_reg.sync3[0]);
    cap1   = ~lnk & (m1 == MODE_CAPTURE) &
             cap_edge(s_reg.csr1, s_reg.sync2[1], s_reg.sync3[1]);

    if (cnt_clr) begin
      s_next.cnt = 16'h0000;
    end else if (tick) begin
      s_next.cnt = nxt;
    end
    if (cap0) begin
      s_next.val0 = s_reg.cnt;
    end
    if (cap1) begin
      s_next.val1 = s_reg.cnt;
    end

    // Pair control follows the last write, switched only at overflow
    if (!lnk) begin
      s_next.act_sel  = 1'b0;
      s_next.last_sel = 1'b0;
    end else if (ovf) begin
      s_next.act_sel = s_next.last_sel;
    end

    // Flags: a second step clears only when armed; a new event wins
    if (do_wr && clr_wrap && s_reg.arm_wrap && may_clr) begin
      s_next.wrap_flag = 1'b0;
      s_next.arm_wrap  = 1'b0;
    end
    if (do_wr && clr0 && s_reg.arm0 && may_clr) begin
      s_next.csr0.flag = 1'b0;
      s_next.arm0      = 1'b0;
    end
    if (do_wr && clr1 && s_reg.arm1 && may_clr) begin
      s_next.csr1.flag = 1'b0;
      s_next.arm1      = 1'b0;
    end
    if (ovf) begin
      s_next.wrap_flag = 1'b1;
      s_next.arm_wrap  = 1'b0;
    end
    if (match0 || cap0) begin
      s_next.csr0.flag = 1'b1;
      s_next.arm0      = 1'b0;
    end
    if (match1 || cap1) begin
      s_next.csr1.flag = 1'b1;
      s_next.arm1      = 1'b0;
    end

    // Pins
    s_next.out0 = pwm_out(s_reg.out0, s_reg.csr0, m0, ovf, match0);
    s_next.out1 = pwm_out(s_reg.out1, s_reg.csr1, m1, ovf, match1);
    s_next.oe0  = (m0 == MODE_COMPARE) | (m0 == MODE_BUFFERED);
    s_next.oe1  = ~lnk & (m1 == MODE_COMPARE);
    s_next.ch1_rel = lnk;
    s_next.ext_in  = (s_reg.ps == PS_EXT);

    // Request stays up in wait mode, so it doubles as the wake signal
    s_next.irq = (s_next.wrap_flag & s_next.wrap_ie) |
                 (s_next.csr0.flag & s_next.csr0.ie) |
                 (~lnk & s_next.csr1.flag & s_next.csr1.ie);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg        <= '0;
      s_reg.halt   <= HALT_RST;
      s_reg.period <= PERIOD_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign axi_rsp.awready      = s_reg.aw_rdy;
  assign axi_rsp.wready       = s_reg.w_rdy;
  assign axi_rsp.bvalid       = s_reg.bvalid;
  assign axi_rsp.bresp        = s_reg.bresp;
  assign axi_rsp.arready      = s_reg.ar_rdy;
  assign axi_rsp.rvalid       = s_reg.rvalid;
  assign axi_rsp.rdata        = s_reg.rdata;
  assign axi_rsp.rresp        = s_reg.rresp;
  assign channel0_pin_out     = s_reg.out0;
  assign channel0_pin_oe      = s_reg.oe0;
  assign channel1_pin_out     = s_reg.out1;
  assign channel1_pin_oe      = s_reg.oe1;
  assign channel1_gpio_release = s_reg.ch1_rel;
  assign ext_clock_pin_input  = s_reg.ext_in;
  assign irq                  = s_reg.irq;

endmodule // tcpwm_top
`default_nettype wire

/* verification/tcpwm_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module tcpwm_monitor
  import tcpwm_pkg::*;
(
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire tcpwm_axi_req_t axi_req,
  input wire tcpwm_axi_rsp_t axi_rsp,
  input wire logic           break_active,
  input wire logic           wait_mode,
  input wire logic           channel0_pin_out,
  input wire logic           channel1_pin_oe,
  input wire logic           channel1_gpio_release
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_b_done;
    axi_rsp.bvalid && axi_req.bready;
  endsequence
  sequence s_rd_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence

  AST_WRITE_ANSWER: assert property (s_wr_take |=> axi_rsp.bvalid)
    else $error("write response missing one cycle after take");
  AST_B_RETURN: assert property (s_b_done |=> axi_rsp.awready && axi_rsp.wready && !axi_rsp.bvalid)
    else $error("write channel not reopened after response");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before accept");
  AST_AW_DROP: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
    else $error("awready stayed high after take");
  AST_READ_ANSWER: assert property (s_rd_take |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read data missing one cycle after take");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data changed before accept");
  AST_WAIT_REFUSE: assert property (s_rd_take ##0 wait_mode |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("register read not refused in wait mode");
  AST_LINK_PIN1: assert property (channel1_gpio_release && $past(channel1_gpio_release) |-> !channel1_pin_oe)
    else $error("channel 1 pin driven while linked");
  AST_BREAK_FREEZE: assert property (break_active[*3] ##0 !axi_rsp.bvalid[*3] |=> $stable(channel0_pin_out))
    else $error("channel 0 pin moved during break");
endmodule // tcpwm_monitor

bind tcpwm_top tcpwm_monitor u_tcpwm_monitor (
  .aclk                 (aclk),
  .aresetn              (aresetn),
  .axi_req              (axi_req),
  .axi_rsp              (axi_rsp),
  .break_active         (break_active),
  .wait_mode            (wait_mode),
  .channel0_pin_out     (channel0_pin_out),
  .channel1_pin_oe      (channel1_pin_oe),
  .channel1_gpio_release(channel1_gpio_release)
);
`default_nettype wire

/* verification/tcpwm_load.sv */
`timescale 1ns/10ps
`default_nettype none
module tcpwm_load (
  input  wire logic channel0_pin_out,
  input  wire logic channel0_pin_oe,
  input  wire logic channel1_pin_out,
  input  wire logic channel1_pin_oe,
  output logic      pin0,
  output logic      pin1
);
  // Pull-ups on both loads, so a released pin reads high, never the last value
  assign pin0 = channel0_pin_oe ? channel0_pin_out : 1'b1;
  assign pin1 = channel1_pin_oe ? channel1_pin_out : 1'b1;
endmodule // tcpwm_load
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
  import tcpwm_pkg::*;
;
  logic           aclk, aresetn, brk, wt, ext;
  tcpwm_axi_req_t req;
  tcpwm_axi_rsp_t rsp;
  logic           p0o, p0e, p1o, p1e, rel, extin, irq, pin0, pin1;
  logic [31:0]    v, c0;
  logic [1:0]     r;
  int             bad_count, n_tests, cyc, i;
  logic [7:0]     csr_tab [3] = '{8'h18, 8'h1B, 8'h1E};
  int             duty_tab [3] = '{0, 100, 60};

  tcpwm_top u_tcpwm_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .break_active(brk), .wait_mode(wt), .channel0_pin_in(pin0), .channel1_pin_in(pin1),
    .external_count_clock(ext), .channel0_pin_out(p0o), .channel0_pin_oe(p0e),
    .channel1_pin_out(p1o), .channel1_pin_oe(p1e), .channel1_gpio_release(rel),
    .ext_clock_pin_input(extin), .irq(irq));
  tcpwm_load u_tcpwm_load (.channel0_pin_out(p0o), .channel0_pin_oe(p0e),
    .channel1_pin_out(p1o), .channel1_pin_oe(p1e), .pin0(pin0), .pin1(pin1));

  always #10 aclk = ~aclk;

  task finish_test;
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      finish_test();
    end
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid && req.bready) begin
        chk("bresp", rsp.bresp, RESP_OKAY);
        req.bready <= 1'b0;
        break;
      end
    end
    if (k == 50) bad_count++;
  endtask

  task rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid && req.rready) begin
        v = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
    if (k == 50) bad_count++;
  endtask

  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, v, e);
  endtask

  // Whole periods in the window, so the count does not depend on phase
  task meas(input int e);
    int h;
    h = 0;
    repeat (100) begin
      @(posedge aclk);
      h += int'(pin0);
    end
    chk("duty", h, e);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    brk = 1'b0;
    wt = 1'b0;
    ext = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc("period", OFS_PERIOD, 32'h0000FFFF);
    rc("ctrl", OFS_CTRL, 32'h00000020);
    rd(8'h40);
    chk("rresp", r, RESP_DECERR);
    wr(OFS_CTRL, 32'h30);
    rc("count", OFS_COUNT, 32'h0);
    wr(OFS_PERIOD, 32'h9);
    wr(OFS_VAL0, 32'h4);
    wr(OFS_CSR0, 32'h1A);
    wr(OFS_CTRL, 32'h0);
    repeat (20) @(posedge aclk);
    meas(40);
    rc("csr0", OFS_CSR0, 32'h9A);
    chk("irq", irq, 1'b0);
    // Lengthen right after overflow, shorten right after the compare
    @(posedge pin0);
    wr(OFS_VAL0, 32'h6);
    meas(60);
    @(negedge pin0);
    wr(OFS_VAL0, 32'h4);
    meas(40);
    for (i = 0; i < 3; i++) begin
      wr(OFS_CSR0, {24'h0, csr_tab[i]});
      repeat (20) @(posedge aclk);
      meas(duty_tab[i]);
    end
    wr(OFS_CTRL, 32'h40);
    repeat (12) @(posedge aclk);
    chk("irq", irq, 1'b1);
    rc("ctrl", OFS_CTRL, 32'hC0);
    brk <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(OFS_COUNT);
    c0 = v;
    repeat (10) @(posedge aclk);
    rc("count", OFS_COUNT, c0);
    brk <= 1'b0;
    // Halt first, so no overflow can disarm the first clear step
    wr(OFS_CTRL, 32'hE0);
    rc("ctrl", OFS_CTRL, 32'hE0);
    brk <= 1'b1;
    wr(OFS_CTRL, 32'h60);
    rc("ctrl", OFS_CTRL, 32'hE0);
    brk <= 1'b0;
    wr(OFS_CTRL, 32'h60);
    rc("ctrl", OFS_CTRL, 32'h60);
    repeat (3) @(posedge aclk);
    chk("irq", irq, 1'b0);
    wr(OFS_CTRL, 32'h40);
    repeat (12) @(posedge aclk);
    wt <= 1'b1;
    rd(OFS_COUNT);
    chk("rresp", r, RESP_SLVERR);
    chk("irq", irq, 1'b1);
    wt <= 1'b0;
    wr(OFS_CTRL, 32'h30);
    wr(OFS_VAL0, 32'h2);
    wr(OFS_CSR1, 32'h1B);
    repeat (2) @(posedge aclk);
    chk("oe1", p1e, 1'b1);
    chk("out1", p1o, 1'b1);
    wr(OFS_CSR0, 32'h3A);
    wr(OFS_CTRL, 32'h0);
    repeat (20) @(posedge aclk);
    meas(20);
    chk("release", rel, 1'b1);
    chk("oe1", p1e, 1'b0);
    wr(OFS_VAL1, 32'h6);
    repeat (30) @(posedge aclk);
    meas(60);
    wr(OFS_CTRL, 32'h37);
    wr(OFS_CTRL, 32'h07);
    chk("extin", extin, 1'b1);
    repeat (5) begin
      ext <= 1'b1;
      repeat (4) @(posedge aclk);
      ext <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
    rc("count", OFS_COUNT, 32'h5);
    finish_test();
  end
endmodule // tb
`default_nettype wire
